// ### hdl/usc_usart_ctrl.sv
// Purpose: USART clock generation, enables and frame control
// Assumes: one clock, synchronous reset, classic Wishbone registers
// Notes:   receive pin owned only while its enable holds; transmit pin until the transmitter drains; clock pin in sync master
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module usc_usart_ctrl
   import usc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq,
   output logic             txd_out,
   output logic             txd_oe,
   input  wire logic        rxd_in,
   output logic             rxd_owned,
   input  wire logic        xck_in,
   output logic             xck_out,
   output logic             xck_oe
);
   logic [7:0]  idx;
   logic [7:0]  wdat;
   logic        req;
   logic        wr;
   logic        rd;
   logic [7:0]  rd_val;
   logic        dbl_reg;
   logic        receiver_enable_bit_reg;
   logic        transmitter_enable_bit_reg;
   logic        csz2_reg;
   logic        tx9_reg;
   logic        xdir_reg;
   logic [6:0]  ctrl_c_reg;
   logic [7:0]  div_lo_reg;
   logic [3:0]  div_hi_reg;
   logic [2:0]  int_st_reg;
   logic [2:0]  int_msk_reg;
   logic [2:0]  ev;
   logic [11:0] baud_cnt_reg;
   logic [11:0] divisor;
   logic        baud_pulse;
   logic [1:0]  mode;
   logic        async_m;
   logic        sync_m;
   logic        master_m;
   logic        int_clk;
   logic [4:0]  lim;
   logic [3:0]  ph_reg;
   logic        ph_last;
   logic [2:0]  xs_reg;
   logic [1:0]  rs_reg;
   logic        rxd;
   logic        x_rise;
   logic        x_fall;
   logic        launch;
   logic        capture;
   logic        tx_tick;
   logic [3:0]  nbits;
   logic        par_en;
   logic        odd;
   logic        xoe_reg;
   // Receiver
   usc_rx_e     rx_st_reg;
   logic [3:0]  rx_cnt_reg;
   logic [3:0]  rx_bit_reg;
   logic [8:0]  rx_sh_reg;
   logic        rx_par_reg;
   logic        rx_perr_reg;
   logic        rx_sample;
   logic        rx_done;
   logic        rx_take;
   logic [8:0]  rx_buf_reg;
   logic        rx_full_reg;
   logic        fe_reg;
   logic        dor_reg;
   logic        upe_reg;
   // Transmitter
   usc_tx_e     tx_st_reg;
   logic [8:0]  tx_buf_reg;
   logic        tx_full_reg;
   logic [8:0]  tx_sh_reg;
   logic [3:0]  tx_bit_reg;
   logic        tx_par_reg;
   logic        txd_reg;
   logic        tx_busy;
   logic        tx_load;
   logic        tx_fin;
   logic        tx_wr;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   assign idx  = wb_adr_i[9:2];
   assign wdat = wb_dat_i[7:0];
   assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr   = req & wb_we_i & wb_sel_i[0];
   assign rd   = req & ~wb_we_i;

   always_comb
   begin
      rd_val = 8'h00;
      if (idx == IDX_CTRL_A)
         rd_val = {rx_full_reg, ~tx_busy & ~tx_full_reg, ~tx_full_reg,
                   fe_reg, dor_reg, upe_reg, dbl_reg, 1'b0};
      else if (idx == IDX_CTRL_B)
         rd_val = {3'h0, receiver_enable_bit_reg, transmitter_enable_bit_reg, csz2_reg, rx_buf_reg[8], tx9_reg};
      else if (idx == IDX_CTRL_C)
         rd_val = {1'b0, ctrl_c_reg};
      else if (idx == IDX_DIV_LO)
         rd_val = div_lo_reg;
      else if (idx == IDX_DIV_HI)
         rd_val = {4'h0, div_hi_reg};
      else if (idx == IDX_DATA)
         rd_val = rx_buf_reg[7:0];
      else if (idx == IDX_PIN)
         rd_val = {7'h00, xdir_reg};
      else if (idx == IDX_INT_ST)
         rd_val = {5'h00, int_st_reg};
      else if (idx == IDX_INT_MSK)
         rd_val = {5'h00, int_msk_reg};
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req;
         if (rd)
            wb_dat_o <= {24'h00_0000, rd_val};
      end
   end

   // Control registers
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         dbl_reg     <= 1'b0;
         receiver_enable_bit_reg    <= 1'b0;
         transmitter_enable_bit_reg    <= 1'b0;
         csz2_reg    <= 1'b0;
         tx9_reg     <= 1'b0;
         xdir_reg    <= 1'b0;
         ctrl_c_reg  <= RST_CTRL_C;
         div_lo_reg  <= 8'h00;
         div_hi_reg  <= 4'h0;
         int_msk_reg <= 3'h0;
      end
      else if (wr)
      begin
         if (idx == IDX_CTRL_A)
            dbl_reg <= wdat[BIT_DBL];
         else if (idx == IDX_CTRL_B)
         begin
            receiver_enable_bit_reg <= wdat[BIT_RECEIVER_ENABLE_BIT];
            transmitter_enable_bit_reg <= wdat[BIT_TRANSMITTER_ENABLE_BIT];
            csz2_reg <= wdat[BIT_CSZ2];
            tx9_reg  <= wdat[BIT_TX9];
         end
         else if (idx == IDX_CTRL_C)
            ctrl_c_reg <= wdat[6:0];
         else if (idx == IDX_DIV_LO)
            div_lo_reg <= wdat;
         else if (idx == IDX_DIV_HI)
            div_hi_reg <= wdat[3:0];
         else if (idx == IDX_PIN)
            xdir_reg <= wdat[BIT_XDIR];
         else if (idx == IDX_INT_MSK)
            int_msk_reg <= wdat[2:0];
      end
   end

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   // mode field encoding
   assign mode     = {1'b0, ctrl_c_reg[6]};
   assign async_m  = (mode == MODE_ASYNC);
   assign sync_m   = (mode == MODE_SYNC);
   assign master_m = sync_m & xdir_reg;
   assign int_clk  = async_m | master_m;
   assign lim      = sync_m ? DIV_SYNC : (dbl_reg ? DIV_DOUBLE : DIV_NORMAL);
   assign nbits    = csz2_reg ? 4'h9 : 4'h5 + {2'b00, ctrl_c_reg[2:1]};
   assign par_en   = ctrl_c_reg[5];
   assign odd      = ctrl_c_reg[4];

   // ----------------------------------------
   // Baud rate generator
   // ----------------------------------------
   // twelve-bit divisor
   assign divisor    = {div_hi_reg, div_lo_reg};
   assign baud_pulse = (baud_cnt_reg == 12'h000);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         baud_cnt_reg <= 12'h000;
      else if (wr && idx == IDX_DIV_LO)
         baud_cnt_reg <= {div_hi_reg, wdat};
      else if (baud_pulse)
         baud_cnt_reg <= divisor;
      else
         baud_cnt_reg <= baud_cnt_reg - 12'h001;
   end

   assign ph_last = ({1'b0, ph_reg} >= lim - 5'h01);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         ph_reg <= 4'h0;
      else if (!int_clk)
         ph_reg <= 4'h0;
      else if (baud_pulse)
         ph_reg <= ph_last ? 4'h0 : ph_reg + 4'h1;
   end

   // ----------------------------------------
   // Transfer clock and pin sync
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         xs_reg  <= 3'h0;
         rs_reg  <= 2'h3;
         xoe_reg <= 1'b0;
      end
      else
      begin
         xs_reg  <= {xs_reg[1:0], xck_in};
         rs_reg  <= {rs_reg[0], rxd_in};
         // pin driven only in sync master
         xoe_reg <= master_m;
      end
   end

   assign rxd     = rs_reg[1];
   assign x_rise  = xs_reg[1] & ~xs_reg[2];
   assign x_fall  = ~xs_reg[1] & xs_reg[2];
   // slave edges follow the pin, master edges the divider
   assign launch  = ctrl_c_reg[0] ? x_fall : x_rise;
   assign capture = master_m ? (baud_pulse & ph_reg == 4'h0)
                             : (ctrl_c_reg[0] ? x_rise : x_fall);
   assign tx_tick = int_clk ? (baud_pulse & ph_last) : (sync_m & launch);
   assign xck_out = ~ph_reg[0] ^ ctrl_c_reg[0];
   assign xck_oe  = xoe_reg;

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   // sample from generator states, or from pin edges in sync slave
   always_comb
   begin
      rx_sample = 1'b0;
      if (sync_m)
         rx_sample = capture;
      else if (async_m && baud_pulse && rx_st_reg != RX_IDLE)
      begin
         if (rx_st_reg == RX_START)
            rx_sample = ({1'b0, rx_cnt_reg} == (lim >> 1) - 5'h01);
         else
            rx_sample = ({1'b0, rx_cnt_reg} == lim - 5'h01);
      end
   end

   assign rx_done = (rx_st_reg == RX_STOP) & rx_sample;
   assign rx_take = rd & (idx == IDX_DATA);

   always_ff @(posedge clk_sys)
   begin
      if (reset || !receiver_enable_bit_reg)
      begin
         rx_st_reg   <= RX_IDLE;
         rx_cnt_reg  <= 4'h0;
         rx_bit_reg  <= 4'h0;
         rx_sh_reg   <= 9'h000;
         rx_par_reg  <= 1'b0;
         rx_perr_reg <= 1'b0;
      end
      else
      begin
         if (baud_pulse)
            rx_cnt_reg <= (rx_st_reg == RX_IDLE || rx_sample) ? 4'h0
                                                              : rx_cnt_reg + 4'h1;
         case (rx_st_reg)
            RX_IDLE:
            begin
               rx_bit_reg <= 4'h0;
               rx_par_reg <= odd;
               if (async_m && baud_pulse && !rxd)
                  rx_st_reg <= RX_START;
               else if (sync_m && rx_sample && !rxd)
                  rx_st_reg <= RX_DATA;
            end
            RX_START:
               if (rx_sample)
                  rx_st_reg <= rxd ? RX_IDLE : RX_DATA;
            RX_DATA:
               if (rx_sample)
               begin
                  rx_sh_reg  <= {rxd, rx_sh_reg[8:1]};
                  rx_par_reg <= rx_par_reg ^ rxd;
                  rx_bit_reg <= rx_bit_reg + 4'h1;
                  if (rx_bit_reg == nbits - 4'h1)
                     rx_st_reg <= par_en ? RX_PAR : RX_STOP;
               end
            RX_PAR:
               if (rx_sample)
               begin
                  rx_perr_reg <= rx_par_reg ^ rxd;
                  rx_st_reg   <= RX_STOP;
               end
            RX_STOP:
               if (rx_sample)
               begin
                  rx_perr_reg <= 1'b0;
                  rx_st_reg   <= RX_IDLE;
               end
            default:
               rx_st_reg <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset || !receiver_enable_bit_reg)
      begin
         rx_buf_reg  <= 9'h000;
         rx_full_reg <= 1'b0;
         fe_reg      <= 1'b0;
         dor_reg     <= 1'b0;
         upe_reg     <= 1'b0;
      end
      else if (rx_done && rx_full_reg && !rx_take)
         dor_reg <= 1'b1;
      else if (rx_done)
      begin
         // align word, ninth bit on top
         rx_buf_reg  <= rx_sh_reg >> (4'h9 - nbits);
         rx_full_reg <= 1'b1;
         fe_reg      <= ~rxd;
         upe_reg     <= rx_perr_reg;
         dor_reg     <= 1'b0;
      end
      else if (rx_take)
      begin
         rx_full_reg <= 1'b0;
         dor_reg     <= 1'b0;
      end
   end

   assign rxd_owned = receiver_enable_bit_reg;

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   assign tx_busy = (tx_st_reg != TX_IDLE);
   assign tx_load = (tx_st_reg == TX_IDLE) & tx_tick & tx_full_reg;
   assign tx_fin  = (tx_st_reg == TX_END) & tx_tick;
   // ninth bit joins data on write
   assign tx_wr   = wr & (idx == IDX_DATA) & transmitter_enable_bit_reg & ~tx_full_reg;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         tx_buf_reg  <= 9'h000;
         tx_full_reg <= 1'b0;
      end
      else if (tx_wr)
      begin
         tx_buf_reg  <= {tx9_reg, wdat};
         tx_full_reg <= 1'b1;
      end
      else if (tx_load)
         tx_full_reg <= 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         tx_st_reg  <= TX_IDLE;
         tx_sh_reg  <= 9'h000;
         tx_bit_reg <= 4'h0;
         tx_par_reg <= 1'b0;
         txd_reg    <= 1'b1;
      end
      else if (tx_tick)
      begin
         case (tx_st_reg)
            TX_IDLE:
               if (tx_full_reg)
               begin
                  txd_reg    <= 1'b0;
                  tx_sh_reg  <= tx_buf_reg;
                  tx_bit_reg <= 4'h0;
                  tx_par_reg <= odd;
                  tx_st_reg  <= TX_DATA;
               end
            TX_DATA:
            begin
               txd_reg    <= tx_sh_reg[0];
               tx_sh_reg  <= {1'b0, tx_sh_reg[8:1]};
               tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
               tx_bit_reg <= tx_bit_reg + 4'h1;
               if (tx_bit_reg == nbits - 4'h1)
                  tx_st_reg <= par_en ? TX_PAR : TX_STOP1;
            end
            TX_PAR:
            begin
               txd_reg   <= tx_par_reg;
               tx_st_reg <= TX_STOP1;
            end
            TX_STOP1:
            begin
               txd_reg   <= 1'b1;
               tx_st_reg <= ctrl_c_reg[3] ? TX_STOP2 : TX_END;
            end
            TX_STOP2:
               tx_st_reg <= TX_END;
            TX_END:
               tx_st_reg <= TX_IDLE;
            default:
               tx_st_reg <= TX_IDLE;
         endcase
      end
   end

   assign txd_out = txd_reg;
   // pin held until shifter and buffer drain
   assign txd_oe  = transmitter_enable_bit_reg | tx_busy | tx_full_reg;

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign ev = {tx_load, tx_fin & ~tx_full_reg, rx_done & ~rx_full_reg};

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         int_st_reg <= 3'h0;
      else if (wr && idx == IDX_INT_ST)
         int_st_reg <= (int_st_reg & ~wdat[2:0]) | ev;
      else
         int_st_reg <= int_st_reg | ev;
   end

   assign irq = |(int_st_reg & int_msk_reg);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [12:0] gap_reg;
   logic        gap_ok_reg;
   logic [4:0]  pc_reg;
   logic        pc_ok_reg;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         gap_reg    <= 13'h0000;
         gap_ok_reg <= 1'b0;
         pc_reg     <= 5'h00;
         pc_ok_reg  <= 1'b0;
      end
      else
      begin
         gap_reg    <= baud_pulse ? 13'h0001 : gap_reg + 13'h0001;
         gap_ok_reg <= (baud_pulse | gap_ok_reg) & ~wr;
         if (tx_tick)
            pc_reg <= 5'h00;
         else if (baud_pulse)
            pc_reg <= pc_reg + 5'h01;
         pc_ok_reg  <= (tx_tick | pc_ok_reg) & ~wr;
      end
   end

   AST_BAUD_RELOAD:
   assert property (@(posedge clk_sys) disable iff (reset)
      baud_pulse && !(wr && idx == IDX_DIV_LO) |=> baud_cnt_reg == $past(divisor))
   else $error("counter did not reload divisor at zero");

   AST_LOW_RELOAD:
   assert property (@(posedge clk_sys) disable iff (reset)
      wr && idx == IDX_DIV_LO |=> baud_cnt_reg == {div_hi_reg, div_lo_reg})
   else $error("counter did not reload on low divisor write");

   AST_BAUD_RATE:
   assert property (@(posedge clk_sys) disable iff (reset)
      baud_pulse && gap_ok_reg |-> gap_reg == {1'b0, divisor} + 13'h0001)
   else $error("generator period is not divisor plus one");

   AST_TX_DIVIDE:
   assert property (@(posedge clk_sys) disable iff (reset)
      tx_tick && int_clk && pc_ok_reg |-> pc_reg + 5'h01 == lim)
   else $error("transmit tick spacing does not match mode");

   AST_TX_RELEASE:
   assert property (@(posedge clk_sys) disable iff (reset)
      $fell(txd_oe) |-> $past(!tx_full_reg && (!tx_busy || tx_fin)))
   else $error("transmit pin released with data pending");

   AST_RX_FLUSH:
   assert property (@(posedge clk_sys) disable iff (reset)
      $fell(receiver_enable_bit_reg) |=> !rx_full_reg && !fe_reg && !dor_reg && !upe_reg)
   else $error("receiver disable left buffer or flags");

   AST_RX_OWN:
   assert property (@(posedge clk_sys) disable iff (reset)
      $rose(rxd_owned) |-> $past(wr && idx == IDX_CTRL_B && wdat[BIT_RECEIVER_ENABLE_BIT]))
   else $error("receive pin taken without enable write");

   AST_XCK_ASYNC:
   assert property (@(posedge clk_sys) disable iff (reset)
      !sync_m ##1 !sync_m |-> !xck_oe)
   else $error("transfer clock driven outside sync mode");

   AST_XCK_MASTER:
   assert property (@(posedge clk_sys) disable iff (reset)
      master_m && $past(master_m) && $changed(xck_out) |-> $past(baud_pulse) || $changed(ctrl_c_reg))
   else $error("master clock moved without generator pulse");

   AST_TX_NINTH:
   assert property (@(posedge clk_sys) disable iff (reset)
      tx_wr |=> tx_full_reg && tx_buf_reg[8] == $past(tx9_reg))
   else $error("ninth transmit bit not captured with data");
endmodule

// ### hdl/usc_pkg.sv
// Purpose: USART clock and control constants
// Assumes: classic Wishbone slave, register data in the low byte
// Notes:   byte address of a register is four times its index
package usc_pkg;
   // ----------------------------------------
   // Register indices
   // ----------------------------------------
   localparam logic [7:0] IDX_CTRL_A  = 8'hC0;
   localparam logic [7:0] IDX_CTRL_B  = 8'hC1;
   localparam logic [7:0] IDX_CTRL_C  = 8'hC2;
   localparam logic [7:0] IDX_DIV_LO  = 8'hC4;
   localparam logic [7:0] IDX_DIV_HI  = 8'hC5;
   localparam logic [7:0] IDX_DATA    = 8'hC6;
   localparam logic [7:0] IDX_PIN     = 8'hC7;
   localparam logic [7:0] IDX_INT_ST  = 8'hC8;
   localparam logic [7:0] IDX_INT_MSK = 8'hC9;
   // ----------------------------------------
   // Reset values and fields
   // ----------------------------------------
   localparam logic [6:0] RST_CTRL_C  = 7'h06;
   localparam int BIT_RECEIVER_ENABLE_BIT = 4;
   localparam int BIT_TRANSMITTER_ENABLE_BIT = 3;
   localparam int BIT_CSZ2 = 2;
   localparam int BIT_TX9  = 0;
   localparam int BIT_DBL  = 1;
   localparam int BIT_XDIR = 0;
   localparam int IRQ_RXC  = 0;
   localparam int IRQ_TXC  = 1;
   localparam int IRQ_EMP  = 2;
   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_SYNC  = 2'h1;
   // ----------------------------------------
   // Divide counts
   // ----------------------------------------
   localparam logic [4:0] DIV_NORMAL = 5'h10;
   localparam logic [4:0] DIV_DOUBLE = 5'h08;
   localparam logic [4:0] DIV_SYNC   = 5'h02;
   typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2,
      RX_PAR = 3'h3, RX_STOP = 3'h4} usc_rx_e;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_DATA = 3'h1, TX_PAR = 3'h2,
      TX_STOP1 = 3'h3, TX_STOP2 = 3'h4, TX_END = 3'h5} usc_tx_e;
endpackage

// ### verification/usc_peer.sv
// Purpose: serial peer driving the receive pin
// Assumes: 8 data bits, no parity, one stop bit
// Notes:   transfer clock stands still at 0 outside clock bursts
`timescale 1ns/100ps
module usc_peer
(
   input  wire logic clk_sys,
   output logic      rxd,
   output logic      transfer_clock_pin
);
   initial
   begin
      rxd = 1'b1;
      transfer_clock_pin = 1'b0;
   end
   task send(input logic [7:0] d, input int bc);
      logic [9:0] fr;
      fr = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd <= fr[i];
         repeat (bc) @(posedge clk_sys);
      end
   endtask
   task clocks(input int n, input int half);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_sys);
         transfer_clock_pin <= 1'b1;
         repeat (half) @(posedge clk_sys);
         transfer_clock_pin <= 1'b0;
         repeat (half - 1) @(posedge clk_sys);
      end
   endtask
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench for usc_usart_ctrl
// Assumes: peer model drives the receive pin
// Notes:   read data is queued and checked on ack
`timescale 1ns/100ps
module tb_top;
   import usc_pkg::*;
   logic        clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
   logic        txd_out, txd_oe, rxd_in, rxd_owned, xck_in, xck_out, xck_oe;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [32:0] exp_q[$];
   logic [32:0] note;
   logic [7:0]  rx_byte;
   int          n_errors, checked, n, div;
   usc_usart_ctrl i_usc_usart_ctrl (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
      .txd_out(txd_out), .txd_oe(txd_oe), .rxd_in(rxd_in), .rxd_owned(rxd_owned),
      .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe));
   usc_peer i_usc_peer (.clk_sys(clk_sys), .rxd(rxd_in), .transfer_clock_pin(xck_in));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One classic cycle; reads note the expected byte
   task bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      if (!we)
         exp_q.push_back({1'b1, 24'h0, d});
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h0, d};
      do
         @(posedge clk_sys);
      while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      #1;
   endtask
   task low_len(output int len);
      int t;
      t = 0;
      while (txd_out !== 1'b0 && t < 300)
      begin
         @(posedge clk_sys);
         t++;
      end
      len = 0;
      while (txd_out === 1'b0 && len < 300)
      begin
         @(posedge clk_sys);
         len++;
      end
   endtask
   always @(posedge clk_sys)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      begin
         note = exp_q.pop_front();
         check(wb_dat_o, note[31:0]);
      end
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial
   begin
      #200000;
      n_errors++;
      stop_test;
   end
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      reset = 1'b1;
      void'($urandom(85251));
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      bus(0, IDX_CTRL_C, 8'h06);
      bus(0, IDX_CTRL_B, 8'h00);
      bus(0, 8'hD0, 8'h00);
      bus(1, IDX_CTRL_C, 8'hC6);
      bus(0, IDX_CTRL_C, 8'h46);
      check(xck_oe, 0);
      for (int m = 0; m < 4; m++)
      begin
         div = $urandom_range(3);
         bus(1, IDX_CTRL_A, (m == 1) ? 8'h02 : 8'h00);
         bus(1, IDX_CTRL_C, (m >= 2) ? 8'h46 : 8'h06);
         bus(1, IDX_PIN, (m == 3) ? 8'h00 : 8'h01);
         bus(1, IDX_DIV_HI, 8'h00);
         bus(1, IDX_DIV_LO, div[7:0]);
         bus(1, IDX_CTRL_B, 8'h08);
         check(txd_oe, 1);
         check(xck_oe, m == 2);
         bus(1, IDX_DATA, 8'hFF);
         if (m == 3)
            fork
               i_usc_peer.clocks(12, 4);
            join_none
         low_len(n);
         check(n, (m == 3) ? 8 : (div + 1) * ((m == 0) ? 16 : (m == 1) ? 8 : 2));
         bus(1, IDX_CTRL_B, 8'h00);
         check(txd_oe, 1);
         n = 0;
         while (txd_oe !== 1'b0 && n < 2000)
         begin
            @(posedge clk_sys);
            n++;
         end
         check(txd_out, 1);
         check(n < 2000, 1);
      end
      bus(1, IDX_CTRL_A, 8'h00);
      bus(1, IDX_CTRL_C, 8'h06);
      bus(1, IDX_DIV_LO, 8'h01);
      bus(1, IDX_INT_MSK, 8'h01);
      bus(1, IDX_CTRL_B, 8'h10);
      check(rxd_owned, 1);
      rx_byte = $urandom;
      i_usc_peer.send(rx_byte, 32);
      repeat (40) @(posedge clk_sys);
      #1;
      check(irq, 1);
      bus(0, IDX_DATA, rx_byte);
      bus(1, IDX_INT_ST, 8'h01);
      check(irq, 0);
      i_usc_peer.send(8'h5A, 32);
      i_usc_peer.send(8'hA5, 32);
      repeat (40) @(posedge clk_sys);
      bus(0, IDX_CTRL_A, 8'hE8);
      bus(1, IDX_CTRL_B, 8'h00);
      check(rxd_owned, 0);
      bus(0, IDX_CTRL_A, 8'h60);
      stop_test;
   end
endmodule
